/* pkg/vsca_defines.svh */
// constants of the virtual scan chain access block
`ifndef VSCA_DEFINES_SVH
`define VSCA_DEFINES_SVH

// ----------------------------------------------------------------
// tap instruction register
// ----------------------------------------------------------------
`define VSCA_IR_W 10
`define VSCA_OP_NODE_SELECT 10'h00E
`define VSCA_OP_NODE_DATA 10'h00C
`define VSCA_IR_RST 10'h3FF
`define VSCA_IR_CAPTURE 10'h001

// ----------------------------------------------------------------
// hub frame layout
// ----------------------------------------------------------------
`define VSCA_HUB_SINST_W 4
`define VSCA_HUB_FORCE_BIT 3
`define VSCA_HUB_SINST_RST 4'h0

`endif

/* pkg/vsca_pkg.sv */
// types of the virtual scan chain access block
package vsca_pkg;
    // tap controller states, gray steps from select through capture, shift and exit1 to update
    typedef enum logic [3:0] {
        VSCA_TLR = 4'h0,
        VSCA_RTI = 4'h1,
        VSCA_SEL_DR = 4'h3,
        VSCA_CAP_DR = 4'h2,
        VSCA_SH_DR = 4'h6,
        VSCA_EX1_DR = 4'h7,
        VSCA_PA_DR = 4'h4,
        VSCA_EX2_DR = 4'hC,
        VSCA_UPD_DR = 4'h5,
        VSCA_SEL_IR = 4'hD,
        VSCA_CAP_IR = 4'hF,
        VSCA_SH_IR = 4'hE,
        VSCA_EX1_IR = 4'hA,
        VSCA_PA_IR = 4'h9,
        VSCA_EX2_IR = 4'h8,
        VSCA_UPD_IR = 4'hB
    } vsca_tap_t;
endpackage

/* verilog/vsca_buf2.sv */
// two-entry buffer with valid/ready on both sides
`timescale 1ns/10ps
module vsca_buf2 #(
    parameter int W = 8
) (
    input wire logic clk_i,             // system clock
    input wire logic rst_b_i,           // async reset, low
    input wire logic in_valid_i,        // word offered
    input wire logic [W-1:0] in_data_i, // offered word
    output logic in_ready_o,            // room for a word
    output logic out_valid_o,           // head word present
    output logic [W-1:0] out_data_o,    // head word
    input wire logic out_ready_i        // drain accepts head
);
    import vsca_pkg::*;

    typedef struct packed {
        logic v0;
        logic v1;
        logic [W-1:0] e0;
        logic [W-1:0] e1;
    } vsca_bst_t;

    vsca_bst_t b_r;
    vsca_bst_t b_nxt;
    logic push;
    logic pop;

    generate
        if (W < 1) begin : g_chk
            $error("vsca_buf2: W must be at least 1");
        end
    endgenerate

    // full and empty come straight from the valid flags
    assign push = in_valid_i && !b_r.v1;
    assign pop = b_r.v0 && out_ready_i;

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        b_nxt = b_r;
        if (pop) begin
            b_nxt.e0 = b_r.e1;
            b_nxt.v0 = b_r.v1;
            b_nxt.v1 = 1'b0;
        end
        if (push) begin
            // head slot if it is (or becomes) free, else tail
            if (!b_nxt.v0) begin
                b_nxt.e0 = in_data_i;
                b_nxt.v0 = 1'b1;
            end else begin
                b_nxt.e1 = in_data_i;
                b_nxt.v1 = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            b_r <= '0;
        end else begin
            b_r <= b_nxt;
        end
    end

    assign in_ready_o = !b_r.v1;
    assign out_valid_o = b_r.v0;
    assign out_data_o = b_r.e0;
endmodule

/* verilog/vsca_top.sv */
// tap, hub chain and soft registers of one scan node
`timescale 1ns/10ps
`include "vsca_defines.svh"
module vsca_top #(
    parameter int SINST_W = 3,               // node soft instruction width
    parameter int SDR_W = 8,                 // soft data register width
    parameter int ADDR_W = 1,                // hub address bits
    parameter logic [ADDR_W-1:0] HUB_ADDR = '0,    // hub's own address
    parameter logic [ADDR_W-1:0] NODE_ADDR = ADDR_W'(1) // this node's address
) (
    input wire logic clk_i,                  // system clock
    input wire logic rst_b_i,                // async reset, low
    input wire logic tck_i,                  // scan clock
    input wire logic tms_i,                  // mode select
    input wire logic tdi_i,                  // scan data in
    output logic tdo_o,                      // scan data out
    output logic tdo_oe_o,                   // tdo driven
    output logic [SINST_W-1:0] soft_instruction_parallel_out_o, // node instruction
    output logic [SDR_W-1:0] sdr_data_o,     // received data word
    output logic sdr_valid_o,                // data word present
    input wire logic sdr_ready_i             // user takes data word
);
    import vsca_pkg::*;

    // the value field never shrinks below the hub's own instruction width
    localparam int VF_W = (SINST_W > `VSCA_HUB_SINST_W) ? SINST_W : `VSCA_HUB_SINST_W;
    localparam int HUB_W = ADDR_W + VF_W;

    // -------------------------------------------------------------
    // state of both domains
    // -------------------------------------------------------------
    typedef struct packed {
        vsca_tap_t st;
        logic [`VSCA_IR_W-1:0] ir;
        logic [`VSCA_IR_W-1:0] ir_sh;
        logic [HUB_W-1:0] hub_sh;
        logic [SDR_W-1:0] dat_sh;
        logic byp;
        logic [SINST_W-1:0] sinst;
        logic [`VSCA_HUB_SINST_W-1:0] hub_sinst;
        logic cap_sel;
        logic [SDR_W-1:0] hold;
        logic dat_tgl;
        logic sinst_tgl;
        logic ack_s1;
        logic ack_s2;
        logic tdo;
        logic tdo_oe;
    } vsca_jst_t;

    typedef struct packed {
        logic dt_s1;
        logic dt_s2;
        logic dt_seen;
        logic vt_s1;
        logic vt_s2;
        logic vt_seen;
        logic [SINST_W-1:0] sinst_out;
    } vsca_cst_t;

    vsca_jst_t j_r;
    vsca_jst_t j_nxt;
    vsca_cst_t c_r;
    vsca_cst_t c_nxt;
    logic busy;
    logic sel_hub;
    logic sel_dat;
    logic [ADDR_W-1:0] upd_addr;
    logic [VF_W-1:0] upd_val;
    logic buf_in_valid;
    logic buf_in_ready;

    generate
        if (SINST_W < 1 || SDR_W < 1 || ADDR_W < 1 || HUB_ADDR == NODE_ADDR) begin : g_chk
            $error("vsca_top: unsupported widths or clashing addresses");
        end
    endgenerate

    // chain selection by opcode and the fields of the hub frame
    assign sel_hub = (j_r.ir == `VSCA_OP_NODE_SELECT);
    assign sel_dat = (j_r.ir == `VSCA_OP_NODE_DATA);
    assign busy = (j_r.dat_tgl != j_r.ack_s2);
    assign upd_addr = j_r.hub_sh[HUB_W-1 -: ADDR_W];
    assign upd_val = j_r.hub_sh[VF_W-1:0];

    // -------------------------------------------------------------
    // scan clock domain: tap, shifters, soft registers
    // -------------------------------------------------------------
    always_comb begin
        j_nxt = j_r;
        j_nxt.ack_s1 = c_r.dt_seen;
        j_nxt.ack_s2 = j_r.ack_s1;
        // tap walk on tms at every rising tck
        unique case (j_r.st)
            VSCA_TLR: j_nxt.st = tms_i ? VSCA_TLR : VSCA_RTI;
            VSCA_RTI: j_nxt.st = tms_i ? VSCA_SEL_DR : VSCA_RTI;
            VSCA_SEL_DR: j_nxt.st = tms_i ? VSCA_SEL_IR : VSCA_CAP_DR;
            VSCA_CAP_DR: j_nxt.st = tms_i ? VSCA_EX1_DR : VSCA_SH_DR;
            VSCA_SH_DR: j_nxt.st = tms_i ? VSCA_EX1_DR : VSCA_SH_DR;
            VSCA_EX1_DR: j_nxt.st = tms_i ? VSCA_UPD_DR : VSCA_PA_DR;
            VSCA_PA_DR: j_nxt.st = tms_i ? VSCA_EX2_DR : VSCA_PA_DR;
            VSCA_EX2_DR: j_nxt.st = tms_i ? VSCA_UPD_DR : VSCA_SH_DR;
            VSCA_UPD_DR: j_nxt.st = tms_i ? VSCA_SEL_DR : VSCA_RTI;
            VSCA_SEL_IR: j_nxt.st = tms_i ? VSCA_TLR : VSCA_CAP_IR;
            VSCA_CAP_IR: j_nxt.st = tms_i ? VSCA_EX1_IR : VSCA_SH_IR;
            VSCA_SH_IR: j_nxt.st = tms_i ? VSCA_EX1_IR : VSCA_SH_IR;
            VSCA_EX1_IR: j_nxt.st = tms_i ? VSCA_UPD_IR : VSCA_PA_IR;
            VSCA_PA_IR: j_nxt.st = tms_i ? VSCA_EX2_IR : VSCA_PA_IR;
            VSCA_EX2_IR: j_nxt.st = tms_i ? VSCA_UPD_IR : VSCA_SH_IR;
            VSCA_UPD_IR: j_nxt.st = tms_i ? VSCA_SEL_DR : VSCA_RTI;
        endcase
        // actions of the state being left
        unique case (j_r.st)
            VSCA_TLR: begin
                j_nxt.ir = `VSCA_IR_RST;
                j_nxt.cap_sel = 1'b0;
            end
            VSCA_CAP_IR: j_nxt.ir_sh = `VSCA_IR_CAPTURE;
            VSCA_SH_IR: j_nxt.ir_sh = {tdi_i, j_r.ir_sh[`VSCA_IR_W-1:1]};
            VSCA_UPD_IR: j_nxt.ir = j_r.ir_sh;
            VSCA_CAP_DR: begin
                j_nxt.byp = 1'b0;
                // forced capture shows the node's instruction, padded
                if (j_r.cap_sel) begin
                    j_nxt.hub_sh = {NODE_ADDR, VF_W'(j_r.sinst)};
                end else begin
                    j_nxt.hub_sh = {HUB_ADDR, VF_W'(j_r.hub_sinst)};
                end
                j_nxt.dat_sh = j_r.hold;
            end
            VSCA_SH_DR: begin
                // one fixed chain length per opcode, lsb leaves first
                if (sel_hub) begin
                    j_nxt.hub_sh = {tdi_i, j_r.hub_sh[HUB_W-1:1]};
                end else if (sel_dat) begin
                    j_nxt.dat_sh = {tdi_i, j_r.dat_sh[SDR_W-1:1]};
                end else begin
                    j_nxt.byp = tdi_i;
                end
            end
            VSCA_UPD_DR: begin
                if (sel_hub && upd_addr == NODE_ADDR) begin
                    j_nxt.sinst = upd_val[SINST_W-1:0];
                    j_nxt.sinst_tgl = !j_r.sinst_tgl;
                end else if (sel_hub && upd_addr == HUB_ADDR) begin
                    j_nxt.hub_sinst = upd_val[`VSCA_HUB_SINST_W-1:0];
                    j_nxt.cap_sel = upd_val[`VSCA_HUB_FORCE_BIT];
                end else if (sel_dat && !busy) begin
                    // a word is refused while the last one is still crossing
                    j_nxt.hold = j_r.dat_sh;
                    j_nxt.dat_tgl = !j_r.dat_tgl;
                end
            end
            default: begin
            end
        endcase
        // tdo presents the bit the host samples on the next rising edge
        j_nxt.tdo_oe = (j_nxt.st == VSCA_SH_IR) || (j_nxt.st == VSCA_SH_DR);
        if (j_nxt.st == VSCA_SH_IR) begin
            j_nxt.tdo = j_nxt.ir_sh[0];
        end else if (j_nxt.st == VSCA_SH_DR && j_nxt.ir == `VSCA_OP_NODE_SELECT) begin
            j_nxt.tdo = j_nxt.hub_sh[0];
        end else if (j_nxt.st == VSCA_SH_DR && j_nxt.ir == `VSCA_OP_NODE_DATA) begin
            j_nxt.tdo = j_nxt.dat_sh[0];
        end else if (j_nxt.st == VSCA_SH_DR) begin
            j_nxt.tdo = j_nxt.byp;
        end else begin
            j_nxt.tdo = 1'b0;
        end
    end

    // scan side register; reset parks the tap in test-logic-reset
    always_ff @(posedge tck_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            j_r <= '0;
            j_r.st <= VSCA_TLR;
            j_r.ir <= `VSCA_IR_RST;
            j_r.hub_sinst <= `VSCA_HUB_SINST_RST;
        end else begin
            j_r <= j_nxt;
        end
    end

    // -------------------------------------------------------------
    // system clock domain: toggle crossings and data buffer
    // -------------------------------------------------------------
    // toggles are only read after two flops; the data word they announce
    // stays still until the handshake closes, the instruction word for a scan
    assign buf_in_valid = (c_r.dt_s2 != c_r.dt_seen);

    always_comb begin
        c_nxt = c_r;
        c_nxt.dt_s1 = j_r.dat_tgl;
        c_nxt.dt_s2 = c_r.dt_s1;
        c_nxt.vt_s1 = j_r.sinst_tgl;
        c_nxt.vt_s2 = c_r.vt_s1;
        // ack only once the buffer takes the word: stall reaches the scan side
        if (buf_in_valid && buf_in_ready) begin
            c_nxt.dt_seen = c_r.dt_s2;
        end
        // the instruction word sits still for a whole scan after its toggle
        if (c_r.vt_s2 != c_r.vt_seen) begin
            c_nxt.vt_seen = c_r.vt_s2;
            c_nxt.sinst_out = j_r.sinst;
        end
    end

    // system side register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            c_r <= '0;
        end else begin
            c_r <= c_nxt;
        end
    end

    vsca_buf2 #(
        .W(SDR_W)
    ) u_buf (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(buf_in_valid),
        .in_data_i(j_r.hold),
        .in_ready_o(buf_in_ready),
        .out_valid_o(sdr_valid_o),
        .out_data_o(sdr_data_o),
        .out_ready_i(sdr_ready_i)
    );

    // outputs come straight from the registers of their own domain
    assign tdo_o = j_r.tdo;
    assign tdo_oe_o = j_r.tdo_oe;
    assign soft_instruction_parallel_out_o = c_r.sinst_out;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    property p_ir_capture;
        @(posedge tck_i) disable iff (!rst_b_i)
        (j_r.st == VSCA_CAP_IR) |=> (j_r.ir_sh == `VSCA_IR_CAPTURE);
    endproperty
    a_ir_capture: assert property (p_ir_capture)
        else $error("ir capture did not load 01 pattern");

    property p_tms_reset;
        @(posedge tck_i) disable iff (!rst_b_i)
        tms_i [*5] |=> (j_r.st == VSCA_TLR);
    endproperty
    a_tms_reset: assert property (p_tms_reset)
        else $error("five tms highs did not reach test logic reset");

    property p_node_write;
        @(posedge tck_i) disable iff (!rst_b_i)
        (j_r.st == VSCA_UPD_DR && sel_hub && upd_addr == NODE_ADDR)
            |=> (j_r.sinst == $past(j_r.hub_sh[SINST_W-1:0])) && $changed(j_r.sinst_tgl);
    endproperty
    a_node_write: assert property (p_node_write)
        else $error("node soft instruction not written by hub scan");

    property p_hub_write;
        @(posedge tck_i) disable iff (!rst_b_i)
        (j_r.st == VSCA_UPD_DR && sel_hub && upd_addr == HUB_ADDR)
            |=> (j_r.cap_sel == $past(j_r.hub_sh[`VSCA_HUB_FORCE_BIT]))
                && $stable(j_r.sinst);
    endproperty
    a_hub_write: assert property (p_hub_write)
        else $error("hub capture scan did not set capture select");

    property p_forced_cap;
        @(posedge tck_i) disable iff (!rst_b_i)
        (j_r.st == VSCA_CAP_DR && j_r.cap_sel)
            |=> (j_r.hub_sh[HUB_W-1 -: ADDR_W] == NODE_ADDR)
                && (j_r.hub_sh[VF_W-1:0] == VF_W'(j_r.sinst));
    endproperty
    a_forced_cap: assert property (p_forced_cap)
        else $error("forced capture did not load padded node instruction");

    property p_hub_tdo;
        @(posedge tck_i) disable iff (!rst_b_i)
        (j_r.st == VSCA_SH_DR && sel_hub && !tms_i) |=> (tdo_o == j_r.hub_sh[0]) && tdo_oe_o;
    endproperty
    a_hub_tdo: assert property (p_hub_tdo)
        else $error("hub chain lsb not presented on tdo");

    property p_data_hand;
        @(posedge tck_i) disable iff (!rst_b_i)
        (j_r.st == VSCA_UPD_DR && sel_dat && !busy)
            |=> busy && (j_r.hold == $past(j_r.dat_sh));
    endproperty
    a_data_hand: assert property (p_data_hand)
        else $error("data scan word not handed over");

    property p_sinst_out;
        @(posedge clk_i) disable iff (!rst_b_i)
        (c_r.vt_s2 != c_r.vt_seen) |=> (soft_instruction_parallel_out_o == $past(j_r.sinst));
    endproperty
    a_sinst_out: assert property (p_sinst_out)
        else $error("parallel soft instruction not refreshed");
endmodule

/* verif/vsca_jtag_host.sv */
// scan controller model that drives the tap of the node
`timescale 1ns/10ps
module vsca_jtag_host (
    output logic tck_o,       // scan clock, still between frames
    output logic tms_o,       // mode select
    output logic tdi_o,       // scan data towards the node
    input wire logic tdo_i,   // scan data from the node
    input wire logic tdo_oe_i // node drives tdo
);
    logic smp;
    logic smp_oe;
    int oe_low;

    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        smp = 1'b0;
        smp_oe = 1'b0;
        oe_low = 0;
    end

    // ----------------------------------------------------------------
    // tck cycles
    // ----------------------------------------------------------------
    // one tck period; tms and tdi move only while tck is low
    task automatic step(input logic tms, input logic tdi);
        tms_o = tms;
        tdi_o = tdi;
        #62.5;
        smp = tdo_i;
        smp_oe = tdo_oe_i;
        tck_o = 1'b1;
        #62.5;
        tck_o = 1'b0;
    endtask

    // five ones reach test-logic-reset from any state, then idle
    task automatic reset_tap();
        repeat (5) step(1'b1, ~tdi_o);
        step(1'b0, ~tdi_o);
    endtask

    // n bits lsb first; tdi flips outside shift so a stale bit never looks valid
    task automatic shift(input int n, input logic [31:0] val, output logic [31:0] cap);
        cap = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, val[i]);
            cap[i] = smp;
            if (smp_oe !== 1'b1) begin
                oe_low++;
            end
        end
        step(1'b1, ~tdi_o);
        step(1'b0, ~tdi_o);
    endtask

    // ----------------------------------------------------------------
    // instruction and data scans, from run-test-idle back to it
    // ----------------------------------------------------------------
    task automatic ir_scan(input logic [9:0] op, output logic [31:0] cap);
        step(1'b1, ~tdi_o);
        step(1'b1, ~tdi_o);
        step(1'b0, ~tdi_o);
        step(1'b0, ~tdi_o);
        shift(10, {22'h0, op}, cap);
    endtask

    // length and value come from the caller, as fixed for the build
    task automatic dr_scan(input int n, input logic [31:0] val, output logic [31:0] cap);
        step(1'b1, ~tdi_o);
        step(1'b0, ~tdi_o);
        step(1'b0, ~tdi_o);
        shift(n, val, cap);
    endtask
endmodule

/* verif/virtual_scan_chain_access_test.sv */
// self-checking bench of the scan node with its scan controller model
`timescale 1ns/10ps
`include "vsca_defines.svh"
module virtual_scan_chain_access_test;
    logic clk_i = 1'b0;
    logic rst_b_i;
    logic tck, tms, tdi, tdo, tdo_oe, sdr_valid, sdr_ready;
    logic [2:0] sip;
    logic [7:0] sdr_data;
    logic [31:0] cap;
    int fail_count = 0;
    int total_checks = 0;

    // 250 MHz system clock
    always #2 clk_i = ~clk_i;

    vsca_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe), .soft_instruction_parallel_out_o(sip),
        .sdr_data_o(sdr_data), .sdr_valid_o(sdr_valid), .sdr_ready_i(sdr_ready));
    vsca_jtag_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
        .tdo_oe_i(tdo_oe));

    // ----------------------------------------------------------------
    // compare and closing
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (fail_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // wait for a head word, check it, take it with a one-cycle ready
    task automatic take(input logic [7:0] exp);
        int n;
        n = 0;
        @(posedge clk_i);
        #1;
        while (sdr_valid !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check({sdr_valid, sdr_data}, {1'b1, exp});
        sdr_ready = 1'b1;
        @(posedge clk_i);
        #1;
        sdr_ready = 1'b0;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check({tdo_oe, sip, sdr_valid, sdr_data}, 32'h0);
        host.reset_tap();
        host.ir_scan(`VSCA_OP_NODE_SELECT, cap);
        check(cap, 32'h001);
    endtask

    // node writes; capture without a forced cycle shows the hub's own value
    task automatic t_node();
        host.dr_scan(5, 32'h11, cap);
        check(cap, 32'h00);
        check(sip, 3'h1);
        host.dr_scan(5, 32'h16, cap);
        check(sip, 3'h6);
        check(tdo_oe, 1'b0);
    endtask

    // forced capture cycle, then the node's padded value comes back
    task automatic t_readback();
        host.dr_scan(5, 32'h0B, cap);
        host.dr_scan(5, 32'h13, cap);
        check(cap, 32'h16);
        check(sip, 3'h3);
    endtask

    // unknown opcode and test-logic-reset both leave the one-bit bypass
    task automatic t_bypass();
        host.ir_scan(10'h155, cap);
        host.dr_scan(2, 32'h1, cap);
        check(cap, 32'h2);
        host.reset_tap();
        host.dr_scan(2, 32'h1, cap);
        check(cap, 32'h2);
    endtask

    // three words while the user stalls; two fill the buffer, one waits
    task automatic t_data();
        host.ir_scan(`VSCA_OP_NODE_DATA, cap);
        host.dr_scan(8, 32'hA5, cap);
        host.dr_scan(8, 32'h5A, cap);
        check(cap, 32'hA5);
        host.dr_scan(8, 32'h3C, cap);
        check(cap, 32'h5A);
        take(8'hA5);
        take(8'h5A);
        take(8'h3C);
        repeat (8) @(posedge clk_i);
        #1;
        check(sdr_valid, 1'b0);
        check(host.oe_low, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        rst_b_i = 1'b0;
        sdr_ready = 1'b0;
        repeat (16) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        t_reset();
        t_node();
        t_readback();
        t_bypass();
        t_data();
        end_sim();
    end

    // the run needs some 20 us of scan traffic; allow fifteen times that
    initial begin
        #300000;
        fail_count++;
        end_sim();
    end
endmodule
